// >>> rtl/wft_trip_logic.sv
// Weak-feed trip logic, voltage-ratio method, per phase
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Receive plus phase undervoltage trips instantly
// - Other protection pickup blocks that phase
// - Receive signal stretched by set time
// - Overcurrent pickup latches phase out of pickup
// - Receive, no undervoltage, residual over 500ms trips
// - Residual flag extended by set time
// - Residual above threshold too long raises alarm
// - Instant element needs healthy channel
// - Per-phase block inputs suppress instant trips
// - Instant element enable setting, off never trips
// - Single-pole allow gates delayed single trips
// - Single-pole may require extended residual
// - Three-pole allow, else delayed multi-pole only reported
// - Delayed element trips after single/multi delay
// - Delayed element always or on channel fail
// - Voltage failure blocks undervoltage selection
// - Threshold is factor times reference voltage
// - Reference follows slowly with time constant
// - Below pole-open level means no undervoltage
// - Shared channel gives one combined echo
// - Trips only in echo-with-trip mode
// - Whole function off unless scope enabled
// - Outputs pickups, single and three-pole trips
module wft_trip_logic
    import wft_pkg::*;
#(
    parameter int TICK_CYCLES = WFT_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Configuration
    input wire logic scope_enabled,
    input wire wft_fn_mode_type function_mode,
    input wire logic instant_path_enable,
    input wire logic delayed_path_mode,
    input wire logic single_pole_allow,
    input wire logic single_pole_needs_residual,
    input wire logic three_pole_allow,
    input wire logic shared_channel_echo,
    input wire logic [14:0] rx_stretch_ms,
    input wire logic [14:0] residual_stretch,
    input wire logic [14:0] residual_alarm_delay,
    input wire logic [14:0] single_pole_delay,
    input wire logic [14:0] multi_pole_delay,
    input wire logic [6:0] uv_factor,
    input wire logic [5:0] ref_time_const,
    // Measurements
    input wire logic [15:0] phase_voltage [3],
    input wire logic [15:0] ref_voltage,
    input wire logic [15:0] pole_open_level,
    input wire logic residual_over,
    input wire logic voltage_fail,
    // Channel and blocking
    input wire logic remote_permit_receive,
    input wire logic channel_healthy,
    input wire logic [2:0] other_pickup,
    input wire logic [2:0] toc_pickup,
    input wire logic [2:0] block_instant,
    input wire logic block_delayed,
    input wire logic echo_req_distance,
    input wire logic echo_req_ground,
    // Indications and commands
    output logic [2:0] undervoltage,
    output logic [2:0] pickup,
    output logic [2:0] trip_1p,
    output logic trip_3p,
    output logic trip_residual,
    output logic trip_any,
    output logic multi_pole_report,
    output logic residual_alarm_flag,
    output logic echo_distance,
    output logic echo_ground,
    output logic echo_common
);

    typedef struct packed {
        logic [WFT_TICK_W-1:0] tick_cnt;
        logic tick;
        logic [14:0] rx_cnt;
        logic [14:0] res_cnt;
        logic [14:0] alarm_cnt;
        logic [9:0] hold_cnt;
        logic [14:0] del_cnt;
        logic [2:0] del_pat;
        logic [2:0] toc_latch;
        logic [15:0] ref_v;
        logic [5:0] tau_cnt;
        logic [2:0] uv;
        logic [2:0] pu;
        logic [2:0] t1p;
        logic t3p;
        logic tres;
        logic tany;
        logic mpr;
        logic alarm;
        logic e_dist;
        logic e_gnd;
        logic e_com;
    } wft_state_type;

    wft_state_type st;
    wft_state_type next_st;

    // Phase count of a set of picked-up phases
    function automatic logic [1:0] count3(input logic [2:0] v);
        count3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
    endfunction

    // Millisecond down-counter step, stops at zero
    function automatic logic [14:0] ms_down(input logic [14:0] c, input logic t);
        ms_down = (t && c != 15'h0000) ? c - WFT_MS_ONE : c;
    endfunction

    // Millisecond up-counter step, saturates
    function automatic logic [14:0] ms_up(input logic [14:0] c, input logic t);
        ms_up = (t && c != WFT_MS_MAX) ? c + WFT_MS_ONE : c;
    endfunction

    logic enabled;
    logic trip_mode;
    logic rx_active;
    logic res_ext;
    logic [2:0] uv_now;
    logic [2:0] blocked;
    logic [2:0] inst;
    logic [2:0] del_pu;
    logic inst_act;
    logic del_act;
    logic [23:0] lhs;
    logic [23:0] rhs;
    logic [16:0] diff;

    always_comb begin
        next_st = st;
        lhs = 24'h000000;
        rhs = 24'h000000;
        diff = 17'h00000;

        next_st.tick = 1'b0;
        if (st.tick_cnt == WFT_TICK_W'(TICK_CYCLES - 1)) begin
            next_st.tick_cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + WFT_TICK_W'(1);
        end

        enabled = scope_enabled && function_mode != WFT_FN_OFF;
        trip_mode = enabled && function_mode == WFT_FN_ECHO_TRIP;

        // reference steps toward measurement every tau ms
        if (st.tick) begin
            if (st.tau_cnt + 6'h01 >= ref_time_const) begin
                next_st.tau_cnt = 6'h00;
                diff = {1'b0, ref_voltage} - {1'b0, st.ref_v};
                next_st.ref_v = st.ref_v
                    + 16'($signed(diff) >>> WFT_REF_SHIFT)
                    + {15'h0000, diff[16] ? 1'b0 : (diff != 17'h00000)};
            end else begin
                next_st.tau_cnt = st.tau_cnt + 6'h01;
            end
        end

        // Undervoltage per phase
        for (int p = 0; p < 3; p++) begin
            lhs = 24'(phase_voltage[p]) * WFT_FACTOR_SCALE;
            rhs = 24'(st.ref_v) * 24'(uv_factor);
            uv_now[p] = enabled && !voltage_fail
                && phase_voltage[p] >= pole_open_level && lhs < rhs;
        end

        // latch after overcurrent pickup, released when function off
        next_st.toc_latch = enabled ? (st.toc_latch | toc_pickup) : 3'b000;
        // other pickup and latch block the phase
        blocked = other_pickup | st.toc_latch | toc_pickup;

        if (remote_permit_receive) begin
            next_st.rx_cnt = rx_stretch_ms;
        end else begin
            next_st.rx_cnt = ms_down(st.rx_cnt, st.tick);
        end
        rx_active = remote_permit_receive || st.rx_cnt != 15'h0000;

        if (residual_over) begin
            next_st.res_cnt = residual_stretch;
        end else begin
            next_st.res_cnt = ms_down(st.res_cnt, st.tick);
        end
        res_ext = residual_over || st.res_cnt != 15'h0000;

        next_st.alarm_cnt = residual_over ? ms_up(st.alarm_cnt, st.tick) : 15'h0000;
        next_st.alarm = enabled && residual_over && st.alarm_cnt > residual_alarm_delay;

        // receive, no undervoltage, residual held over 500 ms
        if (enabled && rx_active && uv_now == 3'b000 && res_ext) begin
            if (st.tick && st.hold_cnt != WFT_RES_HOLD_MAX) begin
                next_st.hold_cnt = st.hold_cnt + 10'h001;
            end
        end else begin
            next_st.hold_cnt = 10'h000;
        end
        next_st.tres = trip_mode && st.hold_cnt > WFT_RES_HOLD;

        inst_act = trip_mode && instant_path_enable && channel_healthy;
        inst = (inst_act && rx_active) ? (uv_now & ~blocked & ~block_instant) : 3'b000;

        del_act = enabled && !block_delayed && (delayed_path_mode || !channel_healthy);
        del_pu = del_act ? (uv_now & ~blocked) : 3'b000;

        // delay restarts whenever the phase set changes
        next_st.del_pat = del_pu;
        if (del_pu == 3'b000 || del_pu != st.del_pat) begin
            next_st.del_cnt = 15'h0000;
        end else begin
            next_st.del_cnt = ms_up(st.del_cnt, st.tick);
        end

        next_st.t1p = 3'b000;
        next_st.t3p = 1'b0;
        next_st.mpr = 1'b0;
        if (count3(inst) == 2'h1) begin
            next_st.t1p = inst;
        end else if (inst != 3'b000) begin
            next_st.t3p = 1'b1;
        end
        if (count3(st.del_pat) == 2'h1 && del_pu == st.del_pat
                && st.del_cnt >= single_pole_delay) begin
            if (trip_mode && single_pole_allow && (!single_pole_needs_residual || res_ext)) begin
                next_st.t1p = next_st.t1p | st.del_pat;
            end
        end
        if (count3(st.del_pat) > 2'h1 && del_pu == st.del_pat) begin
            next_st.mpr = 1'b1;
            if (trip_mode && three_pole_allow && st.del_cnt >= multi_pole_delay) begin
                next_st.t3p = 1'b1;
            end
        end
        if (next_st.tres) begin
            next_st.t3p = 1'b1;
        end
        if (next_st.t3p) begin
            next_st.t1p = 3'b000;
        end
        next_st.uv = uv_now;
        next_st.pu = inst | del_pu;
        next_st.tany = next_st.t3p || next_st.t1p != 3'b000;

        // shared channel sends one combined echo
        if (!enabled) begin
            next_st.e_dist = 1'b0;
            next_st.e_gnd = 1'b0;
            next_st.e_com = 1'b0;
        end else if (shared_channel_echo) begin
            next_st.e_dist = 1'b0;
            next_st.e_gnd = 1'b0;
            next_st.e_com = echo_req_distance || echo_req_ground;
        end else begin
            next_st.e_dist = echo_req_distance;
            next_st.e_gnd = echo_req_ground;
            next_st.e_com = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign undervoltage = st.uv;
    assign pickup = st.pu;
    assign trip_1p = st.t1p;
    assign trip_3p = st.t3p;
    assign trip_residual = st.tres;
    assign trip_any = st.tany;
    assign multi_pole_report = st.mpr;
    assign residual_alarm_flag = st.alarm;
    assign echo_distance = st.e_dist;
    assign echo_ground = st.e_gnd;
    assign echo_common = st.e_com;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_rx_drop;
        (remote_permit_receive && rx_stretch_ms != 15'h0000) ##1 !remote_permit_receive;
    endsequence

    chk_rx_stretch_hold: assert property (s_rx_drop |-> st.rx_cnt != 15'h0000)
        else $error("receive stretch lost at drop");
    chk_inst_needs_uv: assert property ((st.t1p & $past(~uv_now & ~del_pu)) == 3'b000)
        else $error("single trip without undervoltage");
    chk_channel_gate: assert property (!channel_healthy && del_pu == 3'b000
        && !next_st.tres |=> st.t1p == 3'b000 && !st.t3p)
        else $error("instant trip on bad channel");
    chk_inst_enable: assert property (!instant_path_enable && del_pu == 3'b000
        && !next_st.tres |=> st.t1p == 3'b000 && !st.t3p)
        else $error("trip with instant element off");
    chk_inst_block: assert property ((st.t1p & $past(block_instant & ~del_pu)) == 3'b000)
        else $error("single trip in blocked phase");
    chk_block_phase: assert property ((st.pu & $past(other_pickup)) == 3'b000)
        else $error("pickup in blocked phase");
    chk_toc_latch: assert property (toc_pickup != 3'b000 && enabled
        |=> (st.toc_latch & $past(toc_pickup)) == $past(toc_pickup))
        else $error("overcurrent latch not set");
    chk_trip_mode: assert property (function_mode != WFT_FN_ECHO_TRIP |=> !st.tany)
        else $error("trip outside trip mode");
    chk_scope_off: assert property (!scope_enabled |=> st.pu == 3'b000 && !st.e_com)
        else $error("activity with scope disabled");
    chk_vfail_uv: assert property (voltage_fail |=> st.uv == 3'b000)
        else $error("undervoltage during voltage failure");
    chk_residual_hold: assert property (st.tres |-> $past(st.hold_cnt) > WFT_RES_HOLD)
        else $error("residual trip before hold");
    chk_alarm_cause: assert property (st.alarm |-> $past(residual_over))
        else $error("alarm without residual");
    chk_shared_echo: assert property (shared_channel_echo |=> !st.e_dist && !st.e_gnd)
        else $error("independent echo on shared channel");

endmodule

`default_nettype wire

// >>> shared/wft_pkg.sv
// Constants and types shared by the weak-feed trip logic
package wft_pkg;

    // Function mode: off, echo only, echo with trip
    typedef enum logic [1:0] {
        WFT_FN_OFF,
        WFT_FN_ECHO,
        WFT_FN_ECHO_TRIP
    } wft_fn_mode_type;

    // Clock and millisecond tick
    localparam int WFT_CLK_PERIOD_NS = 8;
    localparam int WFT_TICK_NS = 1000000;
    localparam int WFT_TICK_CYCLES = WFT_TICK_NS / WFT_CLK_PERIOD_NS;
    localparam int WFT_TICK_W = 17;

    // Timer widths, settings are in milliseconds up to 30000
    localparam int WFT_MS_W = 15;
    localparam logic [14:0] WFT_MS_MAX = 15'h7FFF;
    localparam logic [14:0] WFT_MS_ONE = 15'h0001;

    // Default settings, in milliseconds
    localparam logic [14:0] WFT_RX_STRETCH_DEF = 15'h028A;
    localparam logic [14:0] WFT_RES_STRETCH_DEF = 15'h0258;
    localparam logic [14:0] WFT_RES_ALARM_DEF = 15'h2710;
    localparam logic [14:0] WFT_SINGLE_DELAY_DEF = 15'h0190;
    localparam logic [14:0] WFT_MULTI_DELAY_DEF = 15'h03E8;

    // Residual hold before three-pole trip, 500 ms
    localparam int WFT_RES_HOLD_MS = 500;
    localparam logic [9:0] WFT_RES_HOLD = 10'(WFT_RES_HOLD_MS);
    localparam logic [9:0] WFT_RES_HOLD_MAX = 10'h3FF;

    // Undervoltage factor in hundredths, 10 to 100, default 70
    localparam logic [6:0] WFT_FACTOR_DEF = 7'h46;
    localparam logic [23:0] WFT_FACTOR_SCALE = 24'h000064;

    // Reference filter: time constant in seconds, 1 to 60, default 5
    localparam logic [5:0] WFT_TAU_DEF = 6'h05;
    localparam int WFT_REF_SHIFT = 10;
    localparam logic [15:0] WFT_REF_RESET = 16'h0000;

endpackage

// >>> tb/wft_remote_end.sv
// Remote line-end model driving the teleprotection receive lines
`timescale 1ns/1ps
`default_nettype none
module wft_remote_end (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Bench commands
    input wire logic send_permit,
    input wire logic link_ok,
    input wire logic slow,
    // Channel lines
    output logic remote_permit_receive,
    output logic channel_healthy
);
    logic [1:0] lag;
    // Transit delay of one or two cycles, slow path models a long channel
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lag <= 2'h0;
            channel_healthy <= 1'b0;
        end else begin
            lag <= {lag[0], send_permit};
            channel_healthy <= link_ok;
        end
    end
    assign remote_permit_receive = slow ? lag[1] : lag[0];
endmodule
`default_nettype wire

// >>> tb/wft_trip_logic_tb.sv
// Self-checking bench for the weak-feed trip logic
`timescale 1ns/1ps
`default_nettype none
module wft_trip_logic_tb;
    import wft_pkg::*;
    // Short tick keeps the half-second hold affordable
    localparam int TK = 4;
    logic clk_sys = 1'b0;
    logic rst_n, scope_enabled, instant_path_enable, delayed_path_mode, single_pole_allow;
    logic single_pole_needs_residual, three_pole_allow, shared_channel_echo, residual_over;
    logic voltage_fail, block_delayed, echo_req_distance, echo_req_ground, slow;
    logic remote_permit_receive, channel_healthy, send_permit, link_ok;
    wft_fn_mode_type function_mode;
    logic [14:0] rx_stretch_ms, residual_stretch, residual_alarm_delay;
    logic [14:0] single_pole_delay, multi_pole_delay;
    logic [6:0] uv_factor;
    logic [5:0] ref_time_const;
    logic [15:0] phase_voltage [3];
    logic [15:0] ref_voltage, pole_open_level;
    logic [2:0] other_pickup, toc_pickup, block_instant, undervoltage, pickup, trip_1p;
    logic trip_3p, trip_residual, trip_any, multi_pole_report, residual_alarm_flag;
    logic echo_distance, echo_ground, echo_common;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;

    wft_remote_end remote_u (.clk_sys, .rst_n, .send_permit, .link_ok, .slow,
        .remote_permit_receive, .channel_healthy);
    wft_trip_logic #(.TICK_CYCLES(TK)) dut_u (.clk_sys, .rst_n, .scope_enabled,
        .function_mode, .instant_path_enable, .delayed_path_mode, .single_pole_allow,
        .single_pole_needs_residual, .three_pole_allow, .shared_channel_echo, .rx_stretch_ms,
        .residual_stretch, .residual_alarm_delay, .single_pole_delay, .multi_pole_delay,
        .uv_factor, .ref_time_const, .phase_voltage, .ref_voltage, .pole_open_level,
        .residual_over, .voltage_fail, .remote_permit_receive, .channel_healthy, .other_pickup,
        .toc_pickup, .block_instant, .block_delayed, .echo_req_distance, .echo_req_ground,
        .undervoltage, .pickup, .trip_1p, .trip_3p, .trip_residual, .trip_any,
        .multi_pole_report, .residual_alarm_flag, .echo_distance, .echo_ground, .echo_common);

    always #4 clk_sys = ~clk_sys;

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic ms(input int n);
        step(n * TK);
    endtask
    task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Deep dip well above the pole-open level, healthy phases at full scale
    task automatic set_uv(input logic [2:0] m);
        for (int i = 0; i < 3; i++)
            phase_voltage[i] = m[i] ? 16'h0010 : 16'hFFFF;
    endtask
    // Clearing the picked-up set restarts the delayed timers
    task automatic restart(input logic [2:0] m);
        set_uv(3'h0);
        step(3);
        set_uv(m);
    endtask
    task automatic disturb(input int k, input logic on);
        case (k)
            0: link_ok = !on;
            1: instant_path_enable = !on;
            2: function_mode = on ? WFT_FN_ECHO : WFT_FN_ECHO_TRIP;
            3: function_mode = on ? WFT_FN_OFF : WFT_FN_ECHO_TRIP;
            4: block_instant = {2'h0, on};
            5: other_pickup = {2'h0, on};
            6: voltage_fail = on;
            default: phase_voltage[0] = on ? 16'h0002 : 16'h0010;
        endcase
    endtask

    task automatic test_instant();
        send_permit = 1'b1;
        link_ok = 1'b1;
        set_uv(3'h1);
        step(4);
        check("undervoltage", undervoltage, 3'h1);
        check("pickup", pickup, 3'h1);
        check("trip", {trip_any, trip_1p[0]}, 3'h3);
        for (int k = 0; k < 8; k++) begin
            disturb(k, 1'b1);
            step(4);
            check("blocked", k >= 6 ? undervoltage : trip_1p, 3'h0);
            disturb(k, 1'b0);
            step(4);
            check("restored", trip_1p, 3'h1);
        end
        toc_pickup = 3'h1;
        step(1);
        toc_pickup = 3'h0;
        step(4);
        check("toc latch", trip_1p, 3'h0);
        disturb(3, 1'b1);
        step(2);
        disturb(3, 1'b0);
        step(4);
        send_permit = 1'b0;
        ms(2);
        check("rx stretched", trip_1p, 3'h1);
        ms(7);
        check("rx expired", trip_1p, 3'h0);
        echo_req_distance = 1'b1;
        echo_req_ground = 1'b1;
        shared_channel_echo = 1'b1;
        step(3);
        check("echo common", {echo_distance, echo_ground, echo_common}, 3'h1);
        shared_channel_echo = 1'b0;
        step(3);
        check("echo split", {echo_distance, echo_ground, echo_common}, 3'h6);
        function_mode = WFT_FN_ECHO;
        echo_req_ground = 1'b0;
        step(3);
        check("echo only", {echo_distance, echo_ground, echo_common}, 3'h4);
        function_mode = WFT_FN_OFF;
        step(3);
        check("echo off", {echo_distance, echo_ground, echo_common}, 3'h0);
        function_mode = WFT_FN_ECHO_TRIP;
        echo_req_distance = 1'b0;
        $display("test instant done");
    endtask

    task automatic test_delayed();
        // Receive on a bad channel with the delayed element blocked: nothing may act
        block_delayed = 1'b1;
        send_permit = 1'b1;
        link_ok = 1'b0;
        ms(13);
        check("delayed blocked", trip_1p | pickup, 3'h0);
        send_permit = 1'b0;
        block_delayed = 1'b0;
        ms(7);
        check("single early", trip_1p, 3'h0);
        ms(6);
        check("single late", trip_1p, 3'h1);
        link_ok = 1'b1;
        step(4);
        check("mode on fail", trip_1p, 3'h0);
        delayed_path_mode = 1'b1;
        ms(13);
        check("mode always", trip_1p, 3'h1);
        delayed_path_mode = 1'b0;
        link_ok = 1'b0;
        restart(3'h3);
        ms(12);
        check("multi early", {multi_pole_report, trip_3p}, 3'h2);
        ms(11);
        check("multi late", {|trip_1p, trip_3p}, 3'h1);
        three_pole_allow = 1'b0;
        restart(3'h3);
        ms(25);
        check("report only", {multi_pole_report, trip_3p}, 3'h2);
        three_pole_allow = 1'b1;
        single_pole_allow = 1'b0;
        restart(3'h1);
        ms(15);
        check("single off", trip_1p, 3'h0);
        single_pole_allow = 1'b1;
        single_pole_needs_residual = 1'b1;
        restart(3'h1);
        ms(15);
        check("no residual", trip_1p, 3'h0);
        residual_over = 1'b1;
        step(6);
        check("with residual", trip_1p, 3'h1);
        residual_over = 1'b0;
        set_uv(3'h0);
        $display("test delayed done");
    endtask

    task automatic test_residual();
        link_ok = 1'b1;
        slow = 1'b1;
        send_permit = 1'b1;
        ms(15);
        residual_over = 1'b1;
        ms(25);
        check("alarm early", residual_alarm_flag, 3'h0);
        ms(10);
        check("alarm late", residual_alarm_flag, 3'h1);
        ms(420);
        check("hold early", trip_residual, 3'h0);
        ms(60);
        check("hold late", {trip_residual, trip_3p}, 3'h3);
        residual_over = 1'b0;
        ms(3);
        check("residual extended", trip_residual, 3'h1);
        ms(14);
        check("extension over", trip_residual, 3'h0);
        set_uv(3'h1);
        step(4);
        check("trip in scope", trip_1p, 3'h1);
        set_uv(3'h3);
        step(4);
        check("instant multi", {|trip_1p, trip_3p}, 3'h1);
        scope_enabled = 1'b0;
        step(4);
        check("scope off", trip_any, 3'h0);
        check("scope off pickup", pickup, 3'h0);
        $display("test residual done");
    endtask

    // Hang guard, the run needs roughly 4000 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 12000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        scope_enabled = 1'b1;
        function_mode = WFT_FN_ECHO_TRIP;
        instant_path_enable = 1'b1;
        delayed_path_mode = 1'b0;
        single_pole_allow = 1'b1;
        single_pole_needs_residual = 1'b0;
        three_pole_allow = 1'b1;
        shared_channel_echo = 1'b0;
        rx_stretch_ms = 15'h0005;
        residual_stretch = 15'h000A;
        residual_alarm_delay = 15'h001E;
        single_pole_delay = 15'h000A;
        multi_pole_delay = 15'h0014;
        uv_factor = WFT_FACTOR_DEF;
        ref_time_const = 6'h01;
        // measurement flags change only just after a clock edge
        set_uv(3'h0);
        ref_voltage = 16'h2000;
        pole_open_level = 16'h0004;
        residual_over = 1'b0;
        voltage_fail = 1'b0;
        other_pickup = 3'h0;
        toc_pickup = 3'h0;
        block_instant = 3'h0;
        block_delayed = 1'b0;
        echo_req_distance = 1'b0;
        echo_req_ground = 1'b0;
        send_permit = 1'b0;
        link_ok = 1'b1;
        slow = 1'b0;
        step(16);
        check("reset trips", {trip_any, trip_3p}, 3'h0);
        rst_n = 1'b1;
        // Reference filter needs time to rise before any undervoltage
        ms(200);
        test_instant();
        test_delayed();
        test_residual();
        finish_test();
    end
endmodule
`default_nettype wire
